// file: host_cpu_model.sv
`timescale 1ns/100ps
`include "scsi_cmd_regs.svh"
module host_cpu_model
(
  input  wire logic               clk,
  input  wire logic [31:0]        rdata,
  output logic      [`ADDR_W-1:0] addr,
  output logic      [31:0]        wdata,
  output logic                    wr,
  output logic                    rd
);
  initial
  begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // each call waits an edge first, so a strobe is never assigned twice in a step
  task automatic write_reg(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic read_reg(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// file: scsi_cmd_pkg.sv
package scsi_cmd_pkg;
  typedef enum logic [1:0] {ST_DISC, ST_INIT, ST_TARGET} role_t;
  typedef enum logic [1:0] {CLS_NONE, CLS_A, CLS_B, CLS_C} cls_t;
  typedef struct packed {
    logic       atn;
    logic       ack;
    logic       rst;
    logic       busy;
  } bus_ctl_t;
  typedef struct packed {
    logic       msg;
    logic       cd;
    logic       io;
  } phase_t;
endpackage

// file: scsi_cmd_regs.svh
`ifndef SCSI_CMD_REGS_SVH
`define SCSI_CMD_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_W          4
`define OFF_COMMAND     4'h0
`define OFF_MODE        4'h1
`define OFF_BASE_COUNT  4'h2
`define OFF_CUR_COUNT   4'h3
`define OFF_STATUS      4'h4
`define OFF_INT_ACK     4'h5
// ----------------------------------------
// field positions and fixed codes
// ----------------------------------------
`define MODE_DMA_BIT    0
`define CODE_SOFT_RST   8'h00
`define CODE_ABORT      8'h01
`define CODE_RELEASE    8'h02
`define CODE_ATN_SET    8'h03
`define CODE_ACK_CLR    8'h04
`define CODE_FLUSH      8'h05
`define CODE_BUS_RST    8'h08
`define CODE_SELECT     8'h10
`define MASK_SELECT     8'hf7
`define CODE_INIT_XFER  8'h12
`define CODE_AUTO_INIT  8'h14
`define MASK_LOW6       8'h3f
`define MASK_AUTO_INIT  8'h37
`define CODE_RESELECT   8'h20
`define CODE_AUTO_TGT   8'h30
`define CODE_TGT_XFER   8'h28
`define MASK_TGT_XFER   8'h38
`define CODE_RESEL_XFER 8'h38
`define MASK_RESEL_XFER 8'h3e
`define CNT_ZERO        24'h00_0000
`define CNT_ONE         24'h00_0001
`define BYTE_ZERO       8'h00
`define EXEC_CYCLES     4'h4
`endif

// file: scsi_command_decoder.sv
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "scsi_cmd_regs.svh"
// What this block does
// - decode housekeeping and bus reset codes 00,01,02,03,04,05,08
// - housekeeping any state; attention set and ack clear only as initiator
// - select is 0001A000, disconnected only, class B with interrupt
// - initiator transfer cc010010, initiator state only, moves data
// - auto initiator cc01A100, disconnected only, one interrupt at end
// - reselect 00100000 and auto target 00110000, disconnected only
// - target receive cc101MC0 / send cc101MC1, target only, phase bits
// - re-receive cc111000 / re-send cc111001, disconnected, end as target
// - counted command loads current counter by count select
// - select 00 copies all; 01 copies upper 16 and clears low byte
// - select 10 clears upper 16, loads low byte; 11 loads one
// - every command is class A, B or C
// - class A except soft reset runs at once, no interrupt
// - soft reset clears role, mode, current count, target phase, atn, ack at once then raises interrupt
// - class B and C synchronised to clock, interrupt at finish
// - selection by another device answered alone, then interrupt if no command runs
// - phase change while a command runs as initiator or target is reported with interrupt
// - mode bit picks programmed io (0) or dma (1) for data phases
module scsi_command_decoder
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [`ADDR_W-1:0]        addr,
  input  wire logic [31:0]               wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [31:0]               rdata,
  input  wire logic                      selected_in,
  input  wire scsi_cmd_pkg::phase_t      phase_in,
  output scsi_cmd_pkg::bus_ctl_t         bus_ctl,
  output logic                           fifo_flush,
  output logic                           dma_mode,
  output logic                           irq
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [7:0]              cmd;
  scsi_cmd_pkg::cls_t      cls;
  logic                    legal;
  logic                    counted;
  logic                    cmd_wr;
  scsi_cmd_pkg::role_t     role_reg;
  scsi_cmd_pkg::role_t     end_role;
  assign cmd    = wdata[7:0];
  assign cmd_wr = wr && addr == `OFF_COMMAND;
  always_comb
  begin
    cls      = scsi_cmd_pkg::CLS_NONE;
    legal    = 1'b0;
    counted  = 1'b0;
    end_role = role_reg;
    if (cmd == `CODE_SOFT_RST || cmd == `CODE_ABORT || cmd == `CODE_RELEASE ||
        cmd == `CODE_FLUSH)
    begin
      cls   = scsi_cmd_pkg::CLS_A;
      legal = 1'b1;
    end
    else if (cmd == `CODE_ATN_SET || cmd == `CODE_ACK_CLR)
    begin
      cls   = scsi_cmd_pkg::CLS_A;
      legal = role_reg == scsi_cmd_pkg::ST_INIT;
    end
    else if (cmd == `CODE_BUS_RST)
    begin
      cls   = scsi_cmd_pkg::CLS_B;
      legal = 1'b1;
    end
    else if ((cmd & `MASK_SELECT) == `CODE_SELECT)
    begin
      cls      = scsi_cmd_pkg::CLS_B;
      legal    = role_reg == scsi_cmd_pkg::ST_DISC;
      end_role = scsi_cmd_pkg::ST_INIT;
    end
    else if ((cmd & `MASK_LOW6) == `CODE_INIT_XFER)
    begin
      cls     = scsi_cmd_pkg::CLS_B;
      legal   = role_reg == scsi_cmd_pkg::ST_INIT;
      counted = 1'b1;
    end
    else if ((cmd & `MASK_AUTO_INIT) == `CODE_AUTO_INIT)
    begin
      cls      = scsi_cmd_pkg::CLS_C;
      legal    = role_reg == scsi_cmd_pkg::ST_DISC;
      counted  = 1'b1;
      end_role = scsi_cmd_pkg::ST_INIT;
    end
    else if (cmd == `CODE_RESELECT || cmd == `CODE_AUTO_TGT)
    begin
      cls      = cmd == `CODE_RESELECT ? scsi_cmd_pkg::CLS_B : scsi_cmd_pkg::CLS_C;
      legal    = role_reg == scsi_cmd_pkg::ST_DISC;
      end_role = scsi_cmd_pkg::ST_TARGET;
    end
    else if ((cmd & `MASK_TGT_XFER) == `CODE_TGT_XFER)
    begin
      cls     = scsi_cmd_pkg::CLS_B;
      legal   = role_reg == scsi_cmd_pkg::ST_TARGET;
      counted = 1'b1;
    end
    else if ((cmd & `MASK_RESEL_XFER) == `CODE_RESEL_XFER)
    begin
      cls      = scsi_cmd_pkg::CLS_C;
      legal    = role_reg == scsi_cmd_pkg::ST_DISC;
      counted  = 1'b1;
      end_role = scsi_cmd_pkg::ST_TARGET;
    end
  end
  // ----------------------------------------
  // execution sequencer
  // ----------------------------------------
  // class B/C take a fixed execution time; bus timing lives elsewhere
  logic                    go;
  logic                    abort_go;
  logic                    soft_rst;
  logic [3:0]              busy_cnt_reg;
  scsi_cmd_pkg::role_t     pend_role_reg;
  logic [7:0]              cmd_reg;
  logic                    done;
  logic                    resp_done;
  logic                    phase_chg;
  logic                    busy_q;
  // abort is the one command taken while another still runs
  assign abort_go = cmd_wr && cmd == `CODE_ABORT;
  assign go       = cmd_wr && legal && (busy_cnt_reg == 4'h0 || abort_go);
  assign soft_rst = go && cmd == `CODE_SOFT_RST;
  assign done     = busy_cnt_reg == 4'h1;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_cnt_reg  <= 4'h0;
      pend_role_reg <= scsi_cmd_pkg::ST_DISC;
      cmd_reg       <= `BYTE_ZERO;
    end
    else if (go && cmd == `CODE_ABORT)
      busy_cnt_reg <= 4'h0;
    else if (go && cls != scsi_cmd_pkg::CLS_A)
    begin
      busy_cnt_reg  <= `EXEC_CYCLES;
      pend_role_reg <= end_role;
      cmd_reg       <= cmd;
    end
    else if (busy_cnt_reg != 4'h0)
      busy_cnt_reg <= busy_cnt_reg - 4'h1;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      role_reg <= scsi_cmd_pkg::ST_DISC;
    else if (soft_rst || (go && cmd == `CODE_RELEASE))
      role_reg <= scsi_cmd_pkg::ST_DISC;
    else if (done)
      role_reg <= cmd_reg == `CODE_BUS_RST ? scsi_cmd_pkg::ST_DISC : pend_role_reg;
    else if (selected_in && role_reg == scsi_cmd_pkg::ST_DISC)
      role_reg <= scsi_cmd_pkg::ST_TARGET;
  end
  assign resp_done = selected_in && role_reg == scsi_cmd_pkg::ST_DISC && busy_cnt_reg == 4'h0;
  // ----------------------------------------
  // phase watch
  // ----------------------------------------
  scsi_cmd_pkg::phase_t    phase_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_reg <= '0;
    else
      phase_reg <= phase_in;
  end
  // idle phase moves are ignored; only a running command reports them
  assign busy_q    = busy_cnt_reg != 4'h0;
  assign phase_chg = role_reg != scsi_cmd_pkg::ST_DISC && busy_q && phase_reg != phase_in;
  // ----------------------------------------
  // counters
  // ----------------------------------------
  logic [23:0]             base_count_reg;
  logic [23:0]             current_transfer_count;
  logic [23:0]             count_next;
  // count select sits in the top two bits of every counted code
  always_comb
  begin
    unique case (cmd[7:6])
      2'b00: count_next = base_count_reg;
      2'b01: count_next = {base_count_reg[23:8], `BYTE_ZERO};
      2'b10: count_next = {16'h0000, base_count_reg[7:0]};
      2'b11: count_next = `CNT_ONE;
    endcase
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      base_count_reg <= `CNT_ZERO;
    else if (wr && addr == `OFF_BASE_COUNT)
      base_count_reg <= wdata[23:0];
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      current_transfer_count <= `CNT_ZERO;
    else if (soft_rst)
      current_transfer_count <= `CNT_ZERO;
    else if (go && counted)
      current_transfer_count <= count_next;
  end
  // ----------------------------------------
  // target information phase
  // ----------------------------------------
  // kept so software can see which phase the last target transfer used
  logic [1:0]              info_phase_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      info_phase_reg <= 2'b00;
    else if (soft_rst)
      info_phase_reg <= 2'b00;
    else if (go && (cmd & `MASK_TGT_XFER) == `CODE_TGT_XFER)
      info_phase_reg <= cmd[2:1];
  end
  // ----------------------------------------
  // mode, bus control, interrupt
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dma_mode <= 1'b0;
    else if (soft_rst)
      dma_mode <= 1'b0;
    else if (wr && addr == `OFF_MODE)
      dma_mode <= wdata[`MODE_DMA_BIT];
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_ctl    <= '0;
      fifo_flush <= 1'b0;
    end
    else
    begin
      fifo_flush <= go && (cmd == `CODE_FLUSH || soft_rst);
      bus_ctl.busy <= (busy_cnt_reg > 4'h1 && !abort_go) || (go && cls != scsi_cmd_pkg::CLS_A);
      bus_ctl.rst  <= (go && cmd == `CODE_BUS_RST) || (bus_ctl.rst && !done && !abort_go);
      // ack stays up after an initiator transfer until software clears it
      if (soft_rst || (go && (cmd == `CODE_RELEASE || cmd == `CODE_ACK_CLR)))
        bus_ctl.ack <= 1'b0;
      else if (done && (cmd_reg & `MASK_LOW6) == `CODE_INIT_XFER)
        bus_ctl.ack <= 1'b1;
      if (soft_rst || (go && cmd == `CODE_RELEASE))
        bus_ctl.atn <= 1'b0;
      else if (go && cmd == `CODE_ATN_SET)
        bus_ctl.atn <= 1'b1;
      else if (go && (cmd & `MASK_AUTO_INIT) == `CODE_AUTO_INIT)
        bus_ctl.atn <= cmd[3];
      else if (go && (cmd & `MASK_SELECT) == `CODE_SELECT)
        bus_ctl.atn <= cmd[3];
    end
  end
  // set beats clear so no event is lost
  logic [2:0]              int_cause_reg;
  logic                    ack_wr;
  assign ack_wr = wr && addr == `OFF_INT_ACK;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      int_cause_reg <= 3'b000;
    else
    begin
      int_cause_reg[0] <= soft_rst || done || (int_cause_reg[0] && !(ack_wr && wdata[0]));
      int_cause_reg[1] <= resp_done || (int_cause_reg[1] && !(ack_wr && wdata[1]));
      int_cause_reg[2] <= phase_chg || (int_cause_reg[2] && !(ack_wr && wdata[2]));
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= int_cause_reg != 3'b000;
  end
  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        `OFF_MODE:       rdata <= {31'h0000_0000, dma_mode};
        `OFF_BASE_COUNT: rdata <= {8'h00, base_count_reg};
        `OFF_CUR_COUNT:  rdata <= {8'h00, current_transfer_count};
        `OFF_STATUS:     rdata <= {17'h0_0000, info_phase_reg, phase_reg, busy_q, int_cause_reg,
                                   role_reg, cmd_reg[7:4]};
        default:         rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end
endmodule

// file: scsi_command_decoder_sva.sv
`timescale 1ns/100ps
`include "scsi_cmd_regs.svh"
module scsi_command_decoder_sva
(
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic [`ADDR_W-1:0]     addr,
  input wire logic [31:0]            wdata,
  input wire logic                   wr,
  input wire logic                   selected_in,
  input wire scsi_cmd_pkg::bus_ctl_t bus_ctl,
  input wire logic                   fifo_flush,
  input wire logic                   dma_mode,
  input wire logic                   irq
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic cmd_wr;
  logic flush_req;
  logic busrst_req;
  logic soft_req;
  logic flush_src;
  logic ack_wr;
  assign cmd_wr     = wr && addr == `OFF_COMMAND && !bus_ctl.busy;
  assign flush_req  = cmd_wr && wdata[7:0] == `CODE_FLUSH;
  assign soft_req   = cmd_wr && wdata[7:0] == `CODE_SOFT_RST;
  assign flush_src  = flush_req || soft_req;
  assign ack_wr     = wr && addr == `OFF_INT_ACK;
  assign busrst_req = cmd_wr && wdata[7:0] == `CODE_BUS_RST;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  irq_hold_a: assert property (irq && !ack_wr && !$past(ack_wr) |=> irq)
    else $error("irq dropped with no host write");
  flush_pulse_a: assert property (fifo_flush |=> !fifo_flush)
    else $error("flush pulse too long");
  flush_cause_a: assert property ($rose(fifo_flush) |-> $past(flush_src))
    else $error("flush without command");
  dma_follow_a: assert property (wr && addr == `OFF_MODE |=> dma_mode == $past(wdata[0]))
    else $error("dma mode not following write");
  busy_start_a: assert property (busrst_req |=> bus_ctl.busy)
    else $error("bus reset did not start");
  class_b_irq_a: assert property (busrst_req |-> ##[5:8] irq)
    else $error("no irq after bus reset");
  class_a_quiet_a: assert property (flush_req && !irq && !selected_in |=> !irq [*4])
    else $error("irq after flush");
  busy_bound_a: assert property ($rose(bus_ctl.busy) |-> ##[1:6] !bus_ctl.busy)
    else $error("busy too long");
  busy_cause_a: assert property ($rose(bus_ctl.busy) |-> $past(cmd_wr) || $past(selected_in))
    else $error("busy with no cause");
  atn_cause_a: assert property ($rose(bus_ctl.atn) |-> $past(bus_ctl.busy) || $past(cmd_wr))
    else $error("atn with no cause");
  ack_cause_a: assert property ($rose(bus_ctl.ack) |-> $past(bus_ctl.busy))
    else $error("ack with no transfer");
endmodule
bind scsi_command_decoder scsi_command_decoder_sva chk (.clk(clk), .rstn(rstn), .addr(addr),
  .wdata(wdata), .wr(wr), .selected_in(selected_in), .bus_ctl(bus_ctl),
  .fifo_flush(fifo_flush), .dma_mode(dma_mode), .irq(irq));

// file: scsi_command_decoder_tb.sv
`timescale 1ns/100ps
`include "scsi_cmd_regs.svh"
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module scsi_command_decoder_tb;
  logic                   clk;
  logic                   rstn;
  logic                   selected_in;
  logic [`ADDR_W-1:0]     addr;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  logic [31:0]            st;
  logic                   wr;
  logic                   rd;
  logic                   fifo_flush;
  logic                   dma_mode;
  logic                   irq;
  scsi_cmd_pkg::phase_t   phase_in;
  scsi_cmd_pkg::bus_ctl_t bus_ctl;
  int                     fail_count;
  int                     tests_run;
  always #4 clk = ~clk;
  host_cpu_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  scsi_command_decoder uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .selected_in(selected_in), .phase_in(phase_in),
    .bus_ctl(bus_ctl), .fifo_flush(fifo_flush), .dma_mode(dma_mode), .irq(irq));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmd(input logic [7:0] c);
    host.write_reg(`OFF_COMMAND, {24'h00_0000, c});
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
  endtask
  // clears every cause; bits past the defined ones are harmless
  task automatic ack;
    host.write_reg(`OFF_INT_ACK, 32'hffff_ffff);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0, "irq not cleared")
  endtask
  task automatic role_is(input logic [1:0] r);
    host.read_reg(`OFF_STATUS, st);
    `CHK(st[5:4], r, "role")
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_class_a;
    host.write_reg(`OFF_MODE, 32'h0000_0001);
    @(negedge clk);
    `CHK(dma_mode, 1'b1, "dma on")
    cmd(`CODE_FLUSH);
    @(negedge clk);
    `CHK(fifo_flush, 1'b1, "flush pulse")
    cmd(`CODE_ATN_SET);
    cmd(8'h3f);
    repeat (8) @(negedge clk);
    `CHK(bus_ctl.atn, 1'b0, "atn set while disconnected")
    `CHK(irq, 1'b0, "irq after class a or junk")
  endtask
  task automatic t_select;
    cmd(`CODE_SELECT);
    wait_irq;
    `CHK(irq, 1'b1, "select irq")
    repeat (5) @(negedge clk);
    `CHK(irq, 1'b1, "irq held")
    `CHK(bus_ctl.atn, 1'b0, "atn without request")
    role_is(2'h1);
    ack;
    cmd(`CODE_ATN_SET);
    repeat (2) @(negedge clk);
    `CHK(bus_ctl.atn, 1'b1, "atn as initiator")
  endtask
  task automatic t_count;
    logic [23:0] exp [4] = '{24'h12_3456, 24'h12_3400, 24'h00_0056, 24'h00_0001};
    host.write_reg(`OFF_BASE_COUNT, 32'h0012_3456);
    for (int cs = 0; cs < 4; cs++)
    begin
      cmd({cs[1:0], 6'h12});
      host.read_reg(`OFF_CUR_COUNT, st);
      `CHK(st[23:0], exp[cs], "count load")
      wait_irq;
      ack;
    end
    `CHK(bus_ctl.ack, 1'b1, "ack after transfer")
    cmd(8'h12);
    cmd(`CODE_ABORT);
    repeat (8) @(negedge clk);
    `CHK(irq, 1'b0, "irq after abort")
    `CHK(bus_ctl.busy, 1'b0, "busy after abort")
    cmd(`CODE_ACK_CLR);
    repeat (2) @(negedge clk);
    `CHK(bus_ctl.ack, 1'b0, "ack cleared")
  endtask
  task automatic t_target;
    cmd(`CODE_RELEASE);
    role_is(2'h0);
    cmd(`CODE_BUS_RST);
    wait_irq;
    `CHK(irq, 1'b1, "bus reset irq")
    ack;
    cmd(`CODE_RESELECT);
    wait_irq;
    ack;
    role_is(2'h2);
    cmd(8'h2b);
    phase_in <= 3'b010;
    wait_irq;
    `CHK(irq, 1'b1, "target send irq")
    repeat (4) @(negedge clk);
    host.read_reg(`OFF_STATUS, st);
    `CHK(st[8:6], 3'b101, "phase and done causes")
    `CHK(st[14:13], 2'b01, "target phase flags")
    ack;
  endtask
  // soft reset brings each automatic sequence back to disconnected
  task automatic t_auto;
    logic [7:0] codes [4] = '{8'h1c, `CODE_AUTO_TGT, 8'h38, 8'h39};
    cmd(`CODE_RELEASE);
    foreach (codes[i])
    begin
      cmd(codes[i]);
      wait_irq;
      `CHK(irq, 1'b1, "class c irq")
      if (i == 0)
        `CHK(bus_ctl.atn, 1'b1, "atn request")
      ack;
      cmd(`CODE_SOFT_RST);
      wait_irq;
      `CHK(irq, 1'b1, "soft reset irq")
      `CHK(dma_mode, 1'b0, "mode after soft reset")
      ack;
      role_is(2'h0);
    end
  endtask
  task automatic t_selected;
    @(posedge clk);
    selected_in <= 1'b1;
    wait_irq;
    `CHK(irq, 1'b1, "response irq")
    @(posedge clk);
    selected_in <= 1'b0;
    ack;
    role_is(2'h2);
  endtask
  initial
  begin
    clk         = 1'b0;
    rstn        = 1'b0;
    selected_in = 1'b0;
    phase_in    = '0;
    fail_count  = 0;
    tests_run   = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    `CHK({irq, bus_ctl, fifo_flush}, 6'h00, "reset outputs")
    t_class_a;
    t_select;
    t_count;
    t_target;
    t_auto;
    t_selected;
    close_out;
  end
  initial
  begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule
